// File: verilog/led_sink_flash_sequencer.sv
// Behaviour
// R01: Function select bit picks steady LED (0) or timed flash (1).
// R02: In flash, trigger source bit picks drive bit (0) or GPIO pin (1).
// R03: In steady LED operation the drive bit simply enables the sink.
// R04: Register trigger: drive bit rising starts flash; hardware clears it at end.
// R05: With GPIO trigger selected, drive bit writes do not start flashes.
// R06: Rate 0 gives one flash per trigger; rate 1 retriggers every 4 s.
// R07: Duration field 9:8 selects 32, 64, 96 or 1024 ms.
// R08: Fall ramp field 5:4: none/0.25/0.5/1 s LED, none/1.95/3.91/7.8 ms flash.
// R09: Rise ramp field 1:0: same choices as the fall ramp, per mode.
// R10: State machine reset clears rate, duration and ramps; drive default fixed.
// R11: Periodic flashes use the same duration and ramps as triggered ones.
`include "sink_b_map.svh"
module led_sink_flash_sequencer
	import sink_b_pkg::*;
#(
	parameter int         LEVEL_W       = 8,
	parameter int         TICK_CYCLES   = `SINKB_CLK_MHZ,
	parameter int         SCALE_SHIFT   = 0,
	parameter logic       DRIVE_DEFAULT = 1'b0
) (
	// Clock, reset, enable
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	// Power state machine reset pulse
	input  wire logic               sm_reset,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Flash trigger pin
	input  wire logic               gpio_flash_trigger,
	// Sink drive
	output logic [LEVEL_W-1:0]      sink_b_output,
	output logic                    sink_b_active
);

	// Elaboration checks
	if (LEVEL_W < 2 || LEVEL_W > 16) begin : g_chk_w
		$error("LEVEL_W must be 2 to 16");
	end
	if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_chk_t
		$error("TICK_CYCLES must be 1 to 4096");
	end
	if (SCALE_SHIFT < 0 || SCALE_SHIFT > 16) begin : g_chk_s
		$error("SCALE_SHIFT must be 0 to 16");
	end

	localparam logic [11:0] CTRL_ADDR = 12'(`SINKB_CTRL_IDX * 4);
	localparam logic [11:0] STAT_ADDR = 12'(`SINKB_STAT_IDX * 4);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// Microsecond count scaled down for short simulations, at least one tick
	function automatic logic [31:0] scaled(input int us);
		logic [31:0] t;
		t = 32'(us) >> SCALE_SHIFT;
		return (t == 32'h0) ? 32'h1 : t;
	endfunction

	// Flash length in ticks
	function automatic logic [31:0] dur_ticks(input logic [1:0] code);
		unique case (code)
			2'b00: return scaled(`SINKB_DUR0_US);
			2'b01: return scaled(`SINKB_DUR1_US);
			2'b10: return scaled(`SINKB_DUR2_US);
			2'b11: return scaled(`SINKB_DUR3_US);
		endcase
	endfunction

	// Ticks between level steps for a ramp code and mode
	function automatic logic [31:0] ramp_step(input logic [1:0] code, input logic flash);
		logic [31:0] t;
		t = 32'h1;
		unique case (code)
			2'b00: t = 32'h1;
			2'b01: t = flash ? scaled(`SINKB_FRAMP1_US) : scaled(`SINKB_LRAMP1_US);
			2'b10: t = flash ? scaled(`SINKB_FRAMP2_US) : scaled(`SINKB_LRAMP2_US);
			2'b11: t = flash ? scaled(`SINKB_FRAMP3_US) : scaled(`SINKB_LRAMP3_US);
		endcase
		t = t >> LEVEL_W;
		return (t == 32'h0) ? 32'h1 : t;
	endfunction

	ctrl_t        ctrl_q;
	flash_state_t st_q;
	logic [15:0]  pre_q;
	logic         tick;
	logic [31:0]  dur_q;
	logic [31:0]  per_q;
	logic         drive_prev_q;
	logic [2:0]   gsync_q;
	logic         glvl_q;
	logic         glvl_prev_q;
	logic         gpio_rise;
	logic         trig_reg;
	logic         trig_gpio;
	logic         per_fire;
	logic         any_trig;
	logic         flash_end;
	logic         apb_acc;
	logic         wr_fire;
	logic         wr_ctrl;
	logic         ramp_target;
	logic [1:0]   ramp_code;
	apb_rsp_t     rsp_d;

	// Microsecond tick prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 16'h0000;
		end else if (ce) begin
			pre_q <= (pre_q == TICK_LAST) ? 16'h0000 : pre_q + 16'h1;
		end
	end
	assign tick = (pre_q == TICK_LAST);

	// Trigger pin: three stages, change accepted when last two agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gsync_q     <= 3'h0;
			glvl_q      <= 1'b0;
			glvl_prev_q <= 1'b0;
		end else if (ce) begin
			gsync_q     <= {gsync_q[1:0], gpio_flash_trigger};
			glvl_prev_q <= glvl_q;
			if (gsync_q[1] == gsync_q[2]) begin
				glvl_q <= gsync_q[2];
			end
		end
	end
	assign gpio_rise = glvl_q & ~glvl_prev_q;

	// APB decode; one wait state, write lands at the completing edge
	assign apb_acc = psel & penable;
	assign wr_fire = apb_acc & pready & pwrite;
	assign wr_ctrl = wr_fire & (paddr == CTRL_ADDR);

	// Trigger sources
	assign trig_reg  = ctrl_q.function_select & ~ctrl_q.trigger_source
		& ctrl_q.drive & ~drive_prev_q;                                    // [R04]
	assign trig_gpio = ctrl_q.function_select & ctrl_q.trigger_source & gpio_rise; // [R02] [R05]
	assign per_fire  = ctrl_q.function_select & ctrl_q.periodic_retrigger
		& tick & (per_q == 32'h0);                                         // [R06]
	assign any_trig  = trig_reg | trig_gpio | per_fire;
	assign flash_end = (st_q == ST_FLASH) & tick & (dur_q == 32'h0);

	// Control register; software write beats the hardware clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q       <= ctrl_t'(`SINKB_CTRL_RST);
			ctrl_q.drive <= 1'b0;
		end else if (ce) begin
			if (sm_reset) begin
				ctrl_q       <= ctrl_t'(`SINKB_CTRL_RST);              // [R10]
				ctrl_q.drive <= DRIVE_DEFAULT;                          // [R10]
			end else if (wr_ctrl) begin
				ctrl_q <= ctrl_t'(pwdata[15:0] & `SINKB_CTRL_WMASK);
			end else if (flash_end && !ctrl_q.trigger_source) begin
				ctrl_q.drive <= 1'b0;                                   // [R04]
			end
		end
	end

	// Drive bit history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_prev_q <= 1'b0;
		end else if (ce) begin
			drive_prev_q <= ctrl_q.drive;
		end
	end

	// Periodic retrigger interval counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_q <= 32'h0;
		end else if (ce) begin
			if (!(ctrl_q.function_select && ctrl_q.periodic_retrigger)) begin
				per_q <= scaled(`SINKB_PERIOD_US) - 32'h1;
			end else if (tick) begin
				per_q <= (per_q == 32'h0) ? scaled(`SINKB_PERIOD_US) - 32'h1 : per_q - 32'h1; // [R06]
			end
		end
	end

	// Flash sequencer; triggers during a flash are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q  <= ST_IDLE;
			dur_q <= 32'h0;
		end else if (ce) begin
			unique case (st_q)
				ST_IDLE: begin
					if (any_trig) begin
						st_q  <= ST_FLASH;                                // [R01]
						dur_q <= dur_ticks(ctrl_q.pulse_length) - 32'h1; // [R07] [R11]
					end
				end
				ST_FLASH: begin
					if (!ctrl_q.function_select || flash_end) begin
						st_q <= ST_IDLE;
					end else if (tick) begin
						dur_q <= dur_q - 32'h1;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Ramp target: drive bit in LED mode, flash window in flash mode
	assign ramp_target = ctrl_q.function_select ? (st_q == ST_FLASH) : ctrl_q.drive; // [R01] [R03]
	assign ramp_code   = ramp_target ? ctrl_q.rise_ramp : ctrl_q.fall_ramp;          // [R08] [R09]

	sink_b_ramp #(
		.LEVEL_W    (LEVEL_W)
	) u_ramp (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.tick       (tick),
		.target_on  (ramp_target),
		.instant    (ramp_code == 2'b00),
		.step_ticks (ramp_step(ramp_code, ctrl_q.function_select)), // [R08] [R09] [R11]
		.level      (sink_b_output)
	);

	// Flash activity flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sink_b_active <= 1'b0;
		end else if (ce) begin
			sink_b_active <= (st_q == ST_FLASH);
		end
	end

	// Read mux and error for unmapped addresses
	always_comb begin
		rsp_d        = '0;
		rsp_d.ready  = apb_acc & ~pready;
		if (paddr == CTRL_ADDR) begin
			rsp_d.rdata[15:0] = ctrl_q;
		end else if (paddr == STAT_ADDR) begin
			rsp_d.rdata[LEVEL_W-1:0]         = sink_b_output;
			rsp_d.rdata[`SINKB_STAT_ACT_BIT]  = (st_q == ST_FLASH);
			rsp_d.rdata[`SINKB_STAT_GPIO_BIT] = glvl_q;
		end else begin
			rsp_d.slverr = 1'b1;
		end
	end

	// Registered APB answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= rsp_d.ready;
			prdata  <= rsp_d.ready ? rsp_d.rdata : 32'h0;
			pslverr <= rsp_d.ready & rsp_d.slverr;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_LED_ON: assert property ( // [R03]
		(ce && !ctrl_q.function_select && ctrl_q.drive && ctrl_q.rise_ramp == 2'b00)[*2]
		|-> sink_b_output == '1)
		else $error("LED enable did not switch sink fully on");
	AST_REG_TRIG: assert property ( // [R04]
		ce && trig_reg && st_q == ST_IDLE |=> st_q == ST_FLASH)
		else $error("Drive bit rise did not start a flash");
	AST_DRIVE_CLR: assert property ( // [R04]
		ce && flash_end && !ctrl_q.trigger_source && !wr_ctrl && !sm_reset |=> !ctrl_q.drive)
		else $error("Drive bit not cleared at flash end");
	AST_GPIO_TRIG: assert property ( // [R02]
		ce && ctrl_q.function_select && ctrl_q.trigger_source && gpio_rise && st_q == ST_IDLE
		|=> st_q == ST_FLASH)
		else $error("GPIO edge did not start a flash");
	AST_GPIO_IGN: assert property ( // [R05]
		ce && ctrl_q.function_select && ctrl_q.trigger_source && st_q == ST_IDLE
		&& !gpio_rise && !per_fire |=> st_q == ST_IDLE)
		else $error("Drive bit started a flash under GPIO source");
	AST_ONE_SHOT: assert property ( // [R06]
		ce && st_q == ST_IDLE && !trig_reg && !trig_gpio
		&& !(ctrl_q.function_select && ctrl_q.periodic_retrigger) |=> st_q == ST_IDLE)
		else $error("Flash started without a trigger");
	AST_DUR: assert property ( // [R07]
		ce && st_q == ST_IDLE && any_trig
		|=> dur_q == dur_ticks($past(ctrl_q.pulse_length)) - 32'h1)
		else $error("Flash length not loaded from duration field");
	AST_PER_FLASH: assert property ( // [R06]
		ce && per_fire && st_q == ST_IDLE |=> st_q == ST_FLASH ##0 sink_b_active == 1'b0)
		else $error("Periodic trigger did not start a flash");
	AST_SM_RST: assert property ( // [R10]
		ce && sm_reset |=> !ctrl_q.periodic_retrigger && ctrl_q.pulse_length == 2'b00
		&& ctrl_q.fall_ramp == 2'b00 && ctrl_q.rise_ramp == 2'b00 && ctrl_q.drive == DRIVE_DEFAULT)
		else $error("State machine reset left fields set");
	AST_OFF_INSTANT: assert property ( // [R08]
		ce && !ramp_target && ctrl_q.fall_ramp == 2'b00 |=> sink_b_output == '0 || !ce)
		else $error("Instant switch-off did not clear the sink");

	COV_REG_FLASH: cover property (trig_reg ##1 st_q == ST_FLASH);
	COV_GPIO_FLASH: cover property (trig_gpio ##1 st_q == ST_FLASH);
	COV_PERIODIC: cover property (per_fire ##1 st_q == ST_FLASH);
	COV_APB_WRITE: cover property (wr_ctrl);

endmodule

// File: shared/sink_b_map.svh
`ifndef SINK_B_MAP_SVH
`define SINK_B_MAP_SVH

// Register indices; byte address is four times the index
`define SINKB_CTRL_IDX   12'h0af
`define SINKB_STAT_IDX   12'h0c0

// Control word: writable bits and reset value
`define SINKB_CTRL_WMASK 16'hf333
`define SINKB_CTRL_RST   16'h0000
`define SINKB_DRIVE_BIT  13

// Status word field positions
`define SINKB_STAT_ACT_BIT  16
`define SINKB_STAT_GPIO_BIT 17

// Timebase
`define SINKB_CLK_MHZ    100

// Flash durations in microseconds
`define SINKB_DUR0_US    32000
`define SINKB_DUR1_US    64000
`define SINKB_DUR2_US    96000
`define SINKB_DUR3_US    1024000

// Ramp times in microseconds, steady and flash operation
`define SINKB_LRAMP1_US  250000
`define SINKB_LRAMP2_US  500000
`define SINKB_LRAMP3_US  1000000
`define SINKB_FRAMP1_US  1950
`define SINKB_FRAMP2_US  3910
`define SINKB_FRAMP3_US  7800

// Periodic retrigger interval in microseconds
`define SINKB_PERIOD_US  4000000

`endif

// File: shared/sink_b_pkg.sv
package sink_b_pkg;

	// Control register layout, bit 15 down to bit 0
	typedef struct packed {
		logic       function_select;
		logic       trigger_source;
		logic       drive;
		logic       periodic_retrigger;
		logic [1:0] rsv_a;
		logic [1:0] pulse_length;
		logic [1:0] rsv_b;
		logic [1:0] fall_ramp;
		logic [1:0] rsv_c;
		logic [1:0] rise_ramp;
	} ctrl_t;

	// Flash sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_FLASH = 2'b10
	} flash_state_t;

	// APB answer bundle
	typedef struct packed {
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} apb_rsp_t;

endpackage

// File: verilog/sink_b_ramp.sv
module sink_b_ramp
	import sink_b_pkg::*;
#(
	parameter int LEVEL_W = 8
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	// Control
	input  wire logic               tick,
	input  wire logic               target_on,
	input  wire logic               instant,
	input  wire logic [31:0]        step_ticks,
	// Level
	output logic [LEVEL_W-1:0]      level
);

	localparam logic [LEVEL_W-1:0] FULL = '1;

	logic [31:0] step_cnt_q;

	// Step timer, restarts whenever the level is on target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt_q <= 32'h0000_0000;
		end else if (ce) begin
			if (instant || level == (target_on ? FULL : '0)) begin
				step_cnt_q <= 32'h0000_0000;
			end else if (tick) begin
				step_cnt_q <= (step_cnt_q + 32'h1 >= step_ticks) ? 32'h0 : step_cnt_q + 32'h1;
			end
		end
	end

	// Level moves one step toward the target, or jumps when instant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= '0;
		end else if (ce) begin
			if (instant) begin
				level <= target_on ? FULL : '0;
			end else if (tick && step_cnt_q + 32'h1 >= step_ticks) begin
				if (target_on && level != FULL) begin
					level <= level + 1'b1;
				end else if (!target_on && level != '0) begin
					level <= level - 1'b1;
				end
			end
		end
	end

endmodule

// File: dv/led_model.sv
module led_model #(
	parameter int LEVEL_W = 8
) (
	// Clock
	input  wire logic               pclk,
	// Sink level and peak reset
	input  wire logic [LEVEL_W-1:0] level,
	input  wire logic               clr,
	// Brightest level seen
	output logic [LEVEL_W-1:0]      peak
);
	timeunit 1ns;
	timeprecision 1ps;

	// Passive LED string: tracks peak brightness since the last clear
	always_ff @(posedge pclk) begin
		if (clr) begin
			peak <= '0;
		end else if (level > peak) begin
			peak <= level;
		end
	end
endmodule

// File: dv/led_sink_flash_sequencer_test.sv
`include "sink_b_map.svh"
module led_sink_flash_sequencer_test
	import sink_b_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// Shortened timebase: 1 cycle per tick, times shifted right by 8
	localparam int         SH     = 8;
	localparam int         PER    = `SINKB_PERIOD_US >> SH;
	localparam logic [11:0] CTRL_A = 12'(`SINKB_CTRL_IDX << 2);
	localparam logic [11:0] STAT_A = 12'(`SINKB_STAT_IDX << 2);
	int                    dur[4] = '{`SINKB_DUR0_US >> SH, `SINKB_DUR1_US >> SH,
	                                  `SINKB_DUR2_US >> SH, `SINKB_DUR3_US >> SH};
	logic                  pclk, presetn, ce, sm_reset, psel, penable, pwrite, gpio, clr;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, r;
	logic                  pready, pslverr, active, e;
	logic [7:0]            level, peak;
	int                    fails, checks, n;

	led_sink_flash_sequencer #(.LEVEL_W(8), .TICK_CYCLES(1), .SCALE_SHIFT(SH), .DRIVE_DEFAULT(1'b0)) DUT (
		.pclk(pclk), .presetn(presetn), .ce(ce), .sm_reset(sm_reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_flash_trigger(gpio), .sink_b_output(level), .sink_b_active(active));

	led_model #(.LEVEL_W(8)) led (.pclk(pclk), .level(level), .clr(clr), .peak(peak));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
	                   output logic [31:0] rd, output logic err);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("apb wait states", 2, k);
	endtask

	task automatic wr(input logic [31:0] d);
		apb(1'b1, CTRL_A, d, r, e);
	endtask

	// Counts edges until the flash window reaches level v
	task automatic wait_act(input logic v, input int max, output int cnt);
		cnt = 0;
		while (active !== v && cnt < max) begin
			@(posedge pclk);
			cnt++;
		end
	endtask

	task automatic t_regs();
		apb(1'b0, CTRL_A, 0, r, e); chk("ctrl reset", 0, r);
		apb(1'b0, 12'h004, 0, r, e); chk("unmapped error", 1, {31'h0, e});
		wr(32'hffff);
		apb(1'b0, CTRL_A, 0, r, e); chk("ctrl writable", 32'hf333, r);
		@(posedge pclk) sm_reset <= 1'b1;
		@(posedge pclk) sm_reset <= 1'b0;
		apb(1'b0, CTRL_A, 0, r, e); chk("state machine reset", 0, r);
		$display("test regs done");
	endtask

	task automatic t_led();
		wr(32'h2000);
		repeat (5) @(posedge pclk);
		chk("led on", 8'hff, level);
		apb(1'b0, STAT_A, 0, r, e); chk("status level", 32'h0000_00ff, r);
		wr(32'h0000);
		repeat (5) @(posedge pclk);
		chk("led off", 0, level);
		wr(32'h2001);
		repeat (20) @(posedge pclk);
		chk("led rise ramp", 1, {31'h0, level !== 0 && level !== 8'hff});
		wr(32'h0010);
		repeat (20) @(posedge pclk);
		chk("led fall ramp", 1, {31'h0, level !== 0});
		wr(32'h0000);
		repeat (5) @(posedge pclk);
		$display("test led done");
	endtask

	task automatic t_flash();
		for (int d = 0; d < 4; d++) begin
			clr <= 1'b1;
			wr(32'ha000 | (d << 8));
			clr <= 1'b0;
			wait_act(1'b1, 20, n);
			chk("flash start", 1, {31'h0, active});
			wait_act(1'b0, 5000, n);
			chk("flash length", dur[d], n);
			apb(1'b0, CTRL_A, 0, r, e); chk("drive self clear", 0, {31'h0, r[13]});
			chk("flash peak", 8'hff, peak);
		end
		$display("test flash done");
	endtask

	task automatic t_gpio();
		wr(32'hc000);
		wr(32'he000);
		wait_act(1'b1, 60, n);
		chk("drive ignored", 0, {31'h0, active});
		@(posedge pclk) gpio <= 1'b1;
		wait_act(1'b1, 20, n);
		chk("pin start", 1, {31'h0, active});
		wait_act(1'b0, 500, n);
		chk("pin length", dur[0], n);
		apb(1'b0, STAT_A, 0, r, e); chk("status pin", 32'h1 << `SINKB_STAT_GPIO_BIT, r);
		@(posedge pclk) gpio <= 1'b0;
		wait_act(1'b1, 300, n);
		chk("single flash", 0, {31'h0, active});
		$display("test gpio done");
	endtask

	task automatic t_periodic();
		wr(32'h9011);
		wait_act(1'b1, PER + 100, n);
		chk("retrigger period", 1, {31'h0, n >= PER - 10 && n <= PER + 10});
		repeat (3) @(posedge pclk);
		chk("periodic rise ramp", 1, {31'h0, level !== 0 && level !== 8'hff});
		wait_act(1'b0, 500, n);
		chk("periodic length", dur[0], n + 3);
		repeat (3) @(posedge pclk);
		chk("flash fall ramp", 1, {31'h0, level !== 0});
		wr(32'h0000);
		$display("test periodic done");
	endtask

	// Clock enable low must freeze a running ramp
	task automatic t_ce();
		logic [7:0] held;
		wr(32'h2003);
		repeat (40) @(posedge pclk);
		ce <= 1'b0;
		@(posedge pclk);
		held = level;
		repeat (40) @(posedge pclk);
		chk("frozen level", {24'h0, held}, {24'h0, level});
		ce <= 1'b1;
		repeat (40) @(posedge pclk);
		chk("level resumes", 1, {31'h0, level > held});
		wr(32'h0000);
		$display("test ce done");
	endtask

	// Watchdog: all tests take about 21000 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		fails++;
		$display("wrong value watchdog expected finish seen hang");
		end_of_test();
	end

	// Main sequence
	initial begin
		{presetn, ce, sm_reset, psel, penable, pwrite, gpio, clr} = 8'h40;
		paddr  = 12'h000;
		pwdata = 32'h0;
		fails  = 0;
		checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_led();
		t_flash();
		t_gpio();
		t_periodic();
		t_ce();
		end_of_test();
	end
endmodule
